// *** bench/serial_config_register_loader_tb.sv ***
// self-checking bench: host and device ends joined over the link
`timescale 1ns/10ps
module serial_config_register_loader_tb;
	// ==========================================================
	// rows: word sent and data field expected
	typedef struct packed {
		logic [31:0] word;
		logic [27:0] data;
	} row_s;
	// reset word first, ascending, calibration last
	// rows 8, 11, 13, 14 carry their fields as given
	localparam row_s ROWS [8] = '{
		'{32'h8007FFF0, 28'h0000010}, '{32'h000505F1, 28'h000505F},
		'{32'h0006FF07, 28'h0006FF0}, '{32'h10000908, 28'h1000090},
		'{32'h0000800B, 28'h0000800}, '{32'h0006C00D, 28'h0006C00},
		'{32'h0800140E, 28'h0800140}, '{32'hC000AB2F, 28'hC000AB2}};
	logic              clk_in;
	logic              rst_n_in;
	logic [11:0]       paddr;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              ref_valid;
	logic [15:0][27:0] regs;
	logic [15:0][27:0] raw_regs;
	logic              cal_pulse;
	logic [7:0][1:0]   sel;
	logic [7:0]        en;
	logic [7:0][8:0]   ratio;
	logic [7:0][11:0]  dly;
	logic [31:0]       wire_word;
	logic [31:0]       seen_word;
	int                wire_bits = 0;
	int                seen_bits = 0;
	int                cal_count = 0;
	int                failures = 0;
	int                checks_done = 0;

	serial_config_bus link_main ();
	serial_config_bus link_raw ();
	serial_config_host #(.HALF_CYCLES(4)) u_serial_config_host (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .reference_valid_in(ref_valid),
		.link(link_main));
	serial_config_device u_serial_config_device (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_main),
		.register_data_out(regs), .calibration_start_out(cal_pulse),
		.output_path_select_out(sel), .output_enable_bit_out(en),
		.output_divide_ratio_out(ratio), .output_delay_ps_out(dly));
	// second device, fed by hand-made frames of the bench
	serial_config_device u_serial_config_device_raw (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_raw),
		.register_data_out(raw_regs), .calibration_start_out(),
		.output_path_select_out(), .output_enable_bit_out(),
		.output_divide_ratio_out(), .output_delay_ps_out());
	serial_link_properties u_serial_link_properties (
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.serial_shift_clock(link_main.serial_shift_clock),
		.serial_data(link_main.serial_data),
		.serial_latch_enable(link_main.serial_latch_enable));

	// ==========================================================
	// clock, monitors, watchdog
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// negedge sampling keeps clear of the pulse's own launch edge
	always @(negedge clk_in) begin
		if (cal_pulse === 1'b1) begin
			cal_count++;
		end
	end
	// shadow of the wire, msb first
	always @(posedge link_main.serial_shift_clock) begin
		if (link_main.serial_latch_enable === 1'b0) begin
			wire_word = {wire_word[30:0], link_main.serial_data};
			wire_bits++;
		end
	end
	always @(posedge link_main.serial_latch_enable) begin
		seen_word = wire_word;
		seen_bits = wire_bits;
		wire_bits = 0;
	end
	initial begin
		repeat (60000) @(posedge clk_in);
		failures++;
		finish_test();
	end

	// ==========================================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one apb transfer; pready and the answer are taken at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge clk_in);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		@(posedge clk_in);
		while (pready !== 1'b1) begin
			@(posedge clk_in);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic stat(output logic [31:0] s);
		logic err;
		apb(1'b0, clock_loader_pkg::OFS_STATUS, 32'h0, s, err);
	endtask : stat

	// send a word, then poll until the link is idle
	task automatic put(input logic [31:0] w, input logic refuse);
		logic [31:0] rd;
		logic err;
		apb(1'b1, clock_loader_pkg::OFS_WORD, w, rd, err);
		check("refusal", 32'(err), 32'(refuse));
		rd = 32'h1;
		while (rd[0] !== 1'b0) begin
			stat(rd);
		end
	endtask : put

	// 40 bits on the raw link; each clock level held 4 cycles, each data bit 8
	task automatic raw_word(input logic [39:0] w);
		for (int i = 39; i >= 0; i--) begin
			link_raw.serial_data <= w[i];
			repeat (4) @(posedge clk_in);
			link_raw.serial_shift_clock <= 1'b1;
			repeat (4) @(posedge clk_in);
			link_raw.serial_shift_clock <= 1'b0;
		end
		repeat (4) @(posedge clk_in);
		link_raw.serial_latch_enable <= 1'b1;
		link_raw.serial_data <= ~w[0];
		repeat (8) @(posedge clk_in);
		link_raw.serial_latch_enable <= 1'b0;
		repeat (8) @(posedge clk_in);
	endtask : raw_word

	task automatic finish_test();
		if (failures == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] rd;
		logic        err;
		logic [27:0] d;
		logic [3:0]  a;
		int          n;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ref_valid = 1'b1;
		rst_n_in = 1'b0;
		link_raw.serial_shift_clock = 1'b0;
		link_raw.serial_data = 1'b0;
		link_raw.serial_latch_enable = 1'b0;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		foreach (ROWS[i]) begin
			n = cal_count;
			a = ROWS[i].word[3:0];
			d = ROWS[i].data;
			put(ROWS[i].word, 1'b0);
			check("wire word", seen_word, ROWS[i].word);
			check("wire bits", 32'(seen_bits), 32'h20);
			check("register", 32'(regs[a]), 32'(d));
			check("cal", 32'(cal_count - n), 32'(a == 4'hF));
			if (a <= 4'h7) begin
				check("select", 32'(sel[a[2:0]]), 32'(d[14:13]));
				check("enable", 32'(en[a[2:0]]), 32'(d[12]));
				check("ratio", 32'(ratio[a[2:0]]), {23'h0, d[11:4], 1'b0});
				check("delay", 32'(dly[a[2:0]]), 32'(d[3:0]) * 32'h96);
			end
		end
		stat(rd);
		check("status", 32'(rd[5:0]), 32'h0);
		// back to back: the second word stalls behind the first
		apb(1'b1, clock_loader_pkg::OFS_WORD, 32'h0006C01D, rd, err);
		put(32'h00000012, 1'b0);
		check("first of pair", 32'(regs[13]), 32'h0006C01);
		check("second of pair", 32'(regs[2]), 32'h1);
		// reserved high bits of an output word go out as zero
		put(32'hFFF80011, 1'b0);
		check("masked", seen_word, 32'h00000011);
		// reference lost: the calibrating word is refused
		n = cal_count;
		ref_valid <= 1'b0;
		repeat (4) @(posedge clk_in);
		put(32'hC000CD2F, 1'b1);
		check("no cal", 32'(cal_count - n), 32'h0);
		check("kept", 32'(regs[15]), 32'hC000AB2);
		stat(rd);
		check("flags set", 32'(rd[5:0] & 6'h16), 32'h16);
		apb(1'b1, clock_loader_pkg::OFS_STATUS, 32'h1C, rd, err);
		stat(rd);
		check("flags w1c", 32'(rd[5:0] & 6'h16), 32'h02);
		ref_valid <= 1'b1;
		repeat (4) @(posedge clk_in);
		put(32'hC000CD2F, 1'b0);
		check("cal rerun", 32'(cal_count - n), 32'h1);
		check("cal word", 32'(regs[15]), 32'hC000CD2);
		stat(rd);
		check("pending", 32'(rd[1]), 32'h0);
		// reset word with junk in its other bits
		put(32'h8007FFF0, 1'b0);
		for (int i = 0; i < 16; i++) begin
			d = (i < 8) ? 28'h0000010 : (i == 13) ? 28'h0002800 :
				(i == 14) ? 28'h08000A0 : 28'h0;
			check("default", 32'(regs[i]), 32'(d));
		end
		apb(1'b0, 12'h008, 32'h0, rd, err);
		check("unmapped", 32'(err), 32'h1);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		check("word read", 32'(err), 32'h1);
		raw_word(40'hA512345673);
		check("last 32", 32'(raw_regs[3]), 32'h1234567);
		// reset in mid-word: nothing latched, link recovers
		apb(1'b1, clock_loader_pkg::OFS_WORD, 32'h00010116, rd, err);
		repeat (100) @(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		check("pins idle", 32'({link_main.serial_shift_clock,
			link_main.serial_latch_enable}), 32'h0);
		check("aborted", 32'(regs[6]), 32'h0000010);
		put(32'h00010116, 1'b0);
		check("after abort", 32'(regs[6]), 32'h0001011);
		finish_test();
	end
endmodule : serial_config_register_loader_tb

// *** bench/serial_link_properties.sv ***
// concurrent checks on the three-wire programming link
`timescale 1ns/10ps
module serial_link_properties (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// link pins
	input wire logic serial_shift_clock,
	input wire logic serial_data,
	input wire logic serial_latch_enable
);
	// ==========================================================
	// helper counter
	logic [5:0] bits;

	// shift clock rises in this word, cleared as latch drops
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || $fell(serial_latch_enable)) begin
			bits <= 6'h00;
		end else if ($rose(serial_shift_clock)) begin
			bits <= bits + 6'h01;
		end
	end

	// ==========================================================
	// properties, fixed to a half period of four cycles
	default clocking main_cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_high_phase;
		serial_shift_clock [*4] ##1 !serial_shift_clock;
	endsequence
	sequence s_low_phase;
		!serial_shift_clock [*4] ##1 serial_shift_clock;
	endsequence
	sequence s_latch_wait;
		!serial_latch_enable [*4] ##1 serial_latch_enable;
	endsequence
	sequence s_latch_pulse;
		serial_latch_enable [*4] ##1 !serial_latch_enable;
	endsequence

	property p_high_phase;
		$rose(serial_shift_clock) |-> s_high_phase;
	endproperty
	property p_low_phase;
		$fell(serial_shift_clock) && bits < 6'h20 |-> s_low_phase;
	endproperty
	property p_latch_wait;
		$fell(serial_shift_clock) && bits == 6'h20 |-> s_latch_wait;
	endproperty
	property p_latch_pulse;
		$rose(serial_latch_enable) |-> s_latch_pulse;
	endproperty
	property p_word_len;
		$rose(serial_latch_enable) |-> bits == 6'h20;
	endproperty
	property p_bit_room;
		$rose(serial_shift_clock) |-> bits < 6'h20;
	endproperty
	property p_data_hold;
		serial_shift_clock && $past(serial_shift_clock)
			|-> $stable(serial_data);
	endproperty
	property p_data_moves_low;
		$changed(serial_data) |-> !serial_shift_clock;
	endproperty
	property p_quiet_latch;
		serial_latch_enable |-> !serial_shift_clock;
	endproperty
	property p_gap;
		$fell(serial_latch_enable) |-> !serial_shift_clock [*3];
	endproperty

	a_high_phase : assert property (p_high_phase)
		else $error("shift clock high phase wrong");
	a_low_phase : assert property (p_low_phase)
		else $error("shift clock low phase wrong");
	a_latch_wait : assert property (p_latch_wait)
		else $error("latch not raised after last bit");
	a_latch_pulse : assert property (p_latch_pulse)
		else $error("latch pulse width wrong");
	a_word_len : assert property (p_word_len)
		else $error("latched word not 32 bits");
	a_bit_room : assert property (p_bit_room)
		else $error("more than 32 bits in a word");
	a_data_hold : assert property (p_data_hold)
		else $error("data moved while shift clock high");
	a_data_moves_low : assert property (p_data_moves_low)
		else $error("data changed with shift clock high");
	a_quiet_latch : assert property (p_quiet_latch)
		else $error("shift clock active during latch");
	a_gap : assert property (p_gap)
		else $error("next word started too soon");
endmodule : serial_link_properties

// *** rtl/clock_loader_pkg.sv ***
// shared constants, types and helpers for the serial register loader
package clock_loader_pkg;

	// ==========================================================
	// word layout
	localparam int          WORD_BITS  = 32;
	localparam int          ADDR_BITS  = 4;
	localparam int          DATA_BITS  = 28;
	localparam int          REG_COUNT  = 16;
	localparam int          OUT_COUNT  = 8;
	localparam int          RESET_BIT  = 31;
	localparam int          RSVD_LO    = 19;
	localparam int          MUX_HI     = 18;
	localparam int          MUX_LO     = 17;
	localparam int          EN_BIT     = 16;
	localparam int          DIV_HI     = 15;
	localparam int          DIV_LO     = 8;
	localparam int          DLY_HI     = 7;
	localparam int          DLY_LO     = 4;

	// ==========================================================
	// register addresses
	localparam logic [3:0]  ADDR_OUT0     = 4'h0;
	localparam logic [3:0]  ADDR_OUT_LAST = 4'h7;
	localparam logic [3:0]  ADDR_NOISE    = 4'h8;
	localparam logic [3:0]  ADDR_BOOST    = 4'h9;
	localparam logic [3:0]  ADDR_PRESCALE = 4'hB;
	localparam logic [3:0]  ADDR_REF_FREQ = 4'hD;
	localparam logic [3:0]  ADDR_REF_DIV  = 4'hE;
	localparam logic [3:0]  ADDR_CAL      = 4'hF;
	localparam logic [15:0] REQUIRED_MASK = 16'hE8FF;

	// ==========================================================
	// power-on defaults of the data field (word bits 31:4)
	localparam logic [27:0] DEF_OUTPUT   = 28'h0000010;
	localparam logic [27:0] DEF_REF_FREQ = 28'h0002800;
	localparam logic [27:0] DEF_REF_DIV  = 28'h08000A0;
	localparam logic [27:0] DEF_OTHER    = 28'h0000000;

	// ==========================================================
	// timing and analog figures
	localparam int          DELAY_STEP_PS   = 150;
	localparam int          MIN_HALF_CYCLES = 3;
	localparam int          MAX_HALF_CYCLES = 256;
	localparam int          LINK_PERIOD_NS  = 80;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          HALF_CYCLES_DEF =
		LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// ==========================================================
	// controller register map (apb)
	localparam logic [11:0] OFS_WORD    = 12'h000;
	localparam logic [11:0] OFS_STATUS  = 12'h004;
	localparam int          ST_BUSY     = 0;
	localparam int          ST_CAL_PEND = 1;
	localparam int          ST_ORDER    = 2;
	localparam int          ST_NO_RESET = 3;
	localparam int          ST_REF_REF  = 4;
	localparam int          ST_COMPLETE = 5;
	localparam int          ST_WRITTEN  = 16;

	// ==========================================================
	// controller link sequencer states
	typedef enum logic [4:0] {
		LINK_IDLE   = 5'h01,
		LINK_LOW    = 5'h02,
		LINK_HIGH   = 5'h04,
		LINK_SETTLE = 5'h08,
		LINK_LATCH  = 5'h10
	} link_state_e;

	// default data field of one register
	function automatic logic [27:0] default_data(input logic [3:0] addr);
		if (addr <= ADDR_OUT_LAST) begin
			return DEF_OUTPUT;
		end else if (addr == ADDR_REF_FREQ) begin
			return DEF_REF_FREQ;
		end else if (addr == ADDR_REF_DIV) begin
			return DEF_REF_DIV;
		end
		return DEF_OTHER;
	endfunction : default_data

	// added delay in picoseconds for a 4-bit delay code
	function automatic logic [11:0] delay_ps(input logic [3:0] code);
		return 12'(int'(code) * DELAY_STEP_PS);
	endfunction : delay_ps

	// divide ratio for an 8-bit divider code (code 1 is divide by 2)
	function automatic logic [8:0] divide_ratio(input logic [7:0] code);
		return {code, 1'b0};
	endfunction : divide_ratio

endpackage : clock_loader_pkg

// *** rtl/pin_sync_edge.sv ***
// two-flop synchroniser with rising-edge detect on the stable stage
`timescale 1ns/10ps
module pin_sync_edge #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// asynchronous levels
	input  wire logic [WIDTH-1:0] async_in,
	// synchronised results
	output logic      [WIDTH-1:0] level_out,
	output logic      [WIDTH-1:0] rise_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] prev;
	} sync_s;

	sync_s s;
	sync_s next_s;

	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync_edge: WIDTH must be at least 1");
	end

	// ==========================================================
	// meta is read only by stable, never by the edge logic
	always_comb begin
		next_s        = s;
		next_s.meta   = async_in;
		next_s.stable = s.meta;
		next_s.prev   = s.stable;
		if (!rst_n_in) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		s <= next_s;
	end

	assign level_out = s.stable;
	assign rise_out  = s.stable & ~s.prev;
endmodule : pin_sync_edge

// *** rtl/serial_config_bus.sv ***
// three-wire programming link between controller and device
`timescale 1ns/10ps
interface serial_config_bus;
	logic serial_shift_clock;
	logic serial_data;
	logic serial_latch_enable;

	modport host (
		output serial_shift_clock,
		output serial_data,
		output serial_latch_enable
	);
	modport device (
		input  serial_shift_clock,
		input  serial_data,
		input  serial_latch_enable
	);
endinterface : serial_config_bus

// *** rtl/serial_config_device.sv ***
// device end: shifts in words and latches them into the register bank
`timescale 1ns/10ps
module serial_config_device (
	// clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        rst_n_in,
	// programming link
	serial_config_bus.device                 link,
	// register bank contents
	output logic [15:0][27:0]                register_data_out,
	output logic                             calibration_start_out,
	// per-output decoded fields
	output logic [7:0][1:0]                  output_path_select_out,
	output logic [7:0]                       output_enable_bit_out,
	output logic [7:0][8:0]                  output_divide_ratio_out,
	output logic [7:0][11:0]                 output_delay_ps_out
);
	localparam int PIN_CLK   = 0;
	localparam int PIN_DATA  = 1;
	localparam int PIN_LATCH = 2;
	// field positions inside the 28-bit data field
	localparam int F_MUX = clock_loader_pkg::MUX_LO - clock_loader_pkg::ADDR_BITS;
	localparam int F_EN  = clock_loader_pkg::EN_BIT - clock_loader_pkg::ADDR_BITS;
	localparam int F_DIV = clock_loader_pkg::DIV_LO - clock_loader_pkg::ADDR_BITS;
	localparam int F_DLY = clock_loader_pkg::DLY_LO - clock_loader_pkg::ADDR_BITS;

	typedef struct packed {
		logic [31:0]      shift;
		logic [15:0][27:0] regs;
		logic             cal_pulse;
	} device_s;

	device_s    s;
	device_s    next_s;
	logic [2:0] pin_level;
	logic [2:0] pin_rise;
	logic [3:0] addr;

	// ==========================================================
	// link pins cross into clk_in before anything reads them
	pin_sync_edge #(.WIDTH(3)) u_pins (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.async_in  ({link.serial_latch_enable, link.serial_data,
			link.serial_shift_clock}),
		.level_out (pin_level),
		.rise_out  (pin_rise)
	);

	assign addr = s.shift[3:0];

	// ==========================================================
	// shift and latch
	always_comb begin
		next_s           = s;
		next_s.cal_pulse = 1'b0;
		// clock edges with latch high are not data bits
		if (pin_rise[PIN_CLK] && !pin_level[PIN_LATCH]) begin
			// only the last 32 bits survive in the shifter
			next_s.shift = {s.shift[30:0], pin_level[PIN_DATA]};
		end
		if (pin_rise[PIN_LATCH]) begin
			if (addr == clock_loader_pkg::ADDR_OUT0 &&
				s.shift[clock_loader_pkg::RESET_BIT]) begin
				// reset word: other data bits are dropped
				for (int i = 0; i < 16; i++) begin
					next_s.regs[i] = clock_loader_pkg::default_data(4'(i));
				end
			end else begin
				next_s.regs[addr] = s.shift[31:4];
			end
			if (addr == clock_loader_pkg::ADDR_CAL) begin
				next_s.cal_pulse = 1'b1;
			end
		end
		if (!rst_n_in) begin
			next_s = '0;
			for (int i = 0; i < 16; i++) begin
				next_s.regs[i] = clock_loader_pkg::default_data(4'(i));
			end
		end
	end

	always_ff @(posedge clk_in) begin
		s <= next_s;
	end

	// ==========================================================
	// outputs are driven from the bank and pulse flops
	assign register_data_out     = s.regs;
	assign calibration_start_out = s.cal_pulse;

	// data field bit n is word bit n+4
	always_comb begin
		for (int i = 0; i < clock_loader_pkg::OUT_COUNT; i++) begin
			output_path_select_out[i]  = s.regs[i][F_MUX +: 2];
			output_enable_bit_out[i]   = s.regs[i][F_EN];
			output_divide_ratio_out[i] = clock_loader_pkg::divide_ratio(
				s.regs[i][F_DIV +: 8]);
			output_delay_ps_out[i]     = clock_loader_pkg::delay_ps(
				s.regs[i][F_DLY +: 4]);
		end
	end
endmodule : serial_config_device

// *** rtl/serial_config_host.sv ***
// controller end: apb-programmed sender of 32-bit programming words
`timescale 1ns/10ps
module serial_config_host #(
	parameter int HALF_CYCLES = clock_loader_pkg::HALF_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// apb slave
	input  wire logic [11:0] paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// reference oscillator health, asynchronous
	input  wire logic        reference_valid_in,
	// programming link
	serial_config_bus.host   link
);
	typedef struct packed {
		clock_loader_pkg::link_state_e state;
		logic [31:0] word;
		logic [5:0]  bit_cnt;
		logic [7:0]  div_cnt;
		logic        sclk;
		logic        sdata;
		logic        latch;
		logic        started;
		logic [3:0]  last_addr;
		logic [15:0] written;
		logic        cal_pending;
		logic        order_err;
		logic        reset_missing;
		logic        ref_refused;
		logic [31:0] prdata;
	} host_s;

	localparam logic [7:0] HALF_LOAD = 8'(HALF_CYCLES - 1);

	host_s       s;
	host_s       next_s;
	logic        ref_ok;
	logic        access;
	logic        hit_word;
	logic        hit_status;
	logic        busy;
	logic        ref_block;
	logic        accept;
	logic [3:0]  waddr;
	logic [31:0] masked;

	if (HALF_CYCLES < clock_loader_pkg::MIN_HALF_CYCLES ||
		HALF_CYCLES > clock_loader_pkg::MAX_HALF_CYCLES) begin : g_bad_half
		$error("serial_config_host: HALF_CYCLES out of range");
	end

	// clear reserved high bits of the output registers
	function automatic logic [31:0] mask_word(input logic [31:0] w);
		logic [31:0] r;
		r = w;
		if (w[3:0] <= clock_loader_pkg::ADDR_OUT_LAST) begin
			r[30:19] = 12'h000;
			if (w[3:0] != clock_loader_pkg::ADDR_OUT0) begin
				r[31] = 1'b0;
			end
		end
		return r;
	endfunction : mask_word

	// status word as software reads it
	function automatic logic [31:0] status_word(input host_s h);
		logic [31:0] r;
		r                                   = 32'h00000000;
		r[clock_loader_pkg::ST_BUSY]        = h.state !=
			clock_loader_pkg::LINK_IDLE;
		r[clock_loader_pkg::ST_CAL_PEND]    = h.cal_pending;
		r[clock_loader_pkg::ST_ORDER]       = h.order_err;
		r[clock_loader_pkg::ST_NO_RESET]    = h.reset_missing;
		r[clock_loader_pkg::ST_REF_REF]     = h.ref_refused;
		// all required addresses written since the reset word
		r[clock_loader_pkg::ST_COMPLETE]    =
			(h.written & clock_loader_pkg::REQUIRED_MASK) ==
			clock_loader_pkg::REQUIRED_MASK;
		r[31:clock_loader_pkg::ST_WRITTEN]  = h.written;
		return r;
	endfunction : status_word

	// ==========================================================
	// reference level crosses into clk_in
	pin_sync_edge #(.WIDTH(1)) u_ref (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.async_in  (reference_valid_in),
		.level_out (ref_ok),
		.rise_out  ()
	);

	// ==========================================================
	// apb decode; a word write stalls while a word is on the link
	assign access     = psel_in && penable_in;
	assign hit_word   = paddr_in == clock_loader_pkg::OFS_WORD;
	assign hit_status = paddr_in == clock_loader_pkg::OFS_STATUS;
	assign busy       = s.state != clock_loader_pkg::LINK_IDLE;
	assign waddr      = pwdata_in[3:0];
	// calibration without a live reference would be wasted
	assign ref_block  = hit_word && pwrite_in &&
		waddr == clock_loader_pkg::ADDR_CAL && !ref_ok;
	assign pready_out = !(hit_word && pwrite_in && busy);
	assign pslverr_out = access && pready_out &&
		(!(hit_word || hit_status) || ref_block ||
		(hit_word && !pwrite_in));
	assign accept     = access && pready_out && hit_word && pwrite_in &&
		!ref_block;
	assign masked     = mask_word(pwdata_in);
	assign prdata_out = s.prdata;

	// ==========================================================
	// register side, sequence checks and link sequencer
	always_comb begin
		next_s = s;
		// read data is fixed in the setup cycle, stable in access
		if (psel_in && !penable_in && !pwrite_in && hit_status) begin
			next_s.prdata = status_word(s);
		end else if (psel_in && !penable_in) begin
			next_s.prdata = 32'h00000000;
		end
		// write-one clears first so a new event in this cycle wins
		if (access && pwrite_in && hit_status) begin
			if (pwdata_in[clock_loader_pkg::ST_ORDER]) begin
				next_s.order_err = 1'b0;
			end
			if (pwdata_in[clock_loader_pkg::ST_NO_RESET]) begin
				next_s.reset_missing = 1'b0;
			end
			if (pwdata_in[clock_loader_pkg::ST_REF_REF]) begin
				next_s.ref_refused = 1'b0;
			end
		end
		if (access && ref_block) begin
			next_s.ref_refused = 1'b1;
		end
		if (accept) begin
			// fields of 8, 9, 11, 13 and 14 pass as software gives
			// them output registers keep
			// select, enable, divider and delay in bits 18:4
			next_s.word    = masked;
			next_s.sdata   = masked[31];
			next_s.bit_cnt = 6'(clock_loader_pkg::WORD_BITS);
			next_s.div_cnt = HALF_LOAD;
			next_s.sclk    = 1'b0;
			next_s.latch   = 1'b0;
			next_s.state   = clock_loader_pkg::LINK_LOW;
			if (waddr == clock_loader_pkg::ADDR_OUT0 &&
				masked[clock_loader_pkg::RESET_BIT]) begin
				// device drops to defaults: restart the sequence
				next_s.started   = 1'b1;
				next_s.written   = 16'h0001;
				next_s.last_addr = clock_loader_pkg::ADDR_OUT0;
			end else begin
				if (!s.started) begin
					next_s.reset_missing = 1'b1;
				end
				if (s.started && waddr <= s.last_addr) begin
					next_s.order_err = 1'b1;
				end
				next_s.written[waddr] = 1'b1;
				next_s.last_addr      = waddr;
			end
			// reference setup changed: calibration must be rerun
			if (waddr == clock_loader_pkg::ADDR_REF_FREQ ||
				waddr == clock_loader_pkg::ADDR_REF_DIV) begin
				next_s.cal_pending = 1'b1;
			end else if (waddr == clock_loader_pkg::ADDR_CAL) begin
				next_s.cal_pending = 1'b0;
			end
		end
		// link sequencer: data moves only while the clock is low
		if (s.state != clock_loader_pkg::LINK_IDLE && s.div_cnt != 8'h00)
		begin
			next_s.div_cnt = s.div_cnt - 8'h01;
		end else begin
			case (s.state)
				clock_loader_pkg::LINK_IDLE: begin
				end
				clock_loader_pkg::LINK_LOW: begin
					next_s.sclk    = 1'b1;
					next_s.div_cnt = HALF_LOAD;
					next_s.state   = clock_loader_pkg::LINK_HIGH;
				end
				clock_loader_pkg::LINK_HIGH: begin
					next_s.sclk    = 1'b0;
					next_s.div_cnt = HALF_LOAD;
					next_s.bit_cnt = s.bit_cnt - 6'h01;
					if (s.bit_cnt == 6'h01) begin
						next_s.state = clock_loader_pkg::LINK_SETTLE;
					end else begin
						next_s.word  = {s.word[30:0], 1'b0};
						next_s.sdata = s.word[30];
						next_s.state = clock_loader_pkg::LINK_LOW;
					end
				end
				clock_loader_pkg::LINK_SETTLE: begin
					// latch rises only after the 32nd bit
					next_s.latch   = 1'b1;
					next_s.div_cnt = HALF_LOAD;
					next_s.state   = clock_loader_pkg::LINK_LATCH;
				end
				clock_loader_pkg::LINK_LATCH: begin
					next_s.latch = 1'b0;
					next_s.sdata = 1'b0;
					next_s.state = clock_loader_pkg::LINK_IDLE;
				end
				default: begin
					next_s.state = clock_loader_pkg::LINK_IDLE;
				end
			endcase
		end
		if (!rst_n_in) begin
			next_s       = '0;
			next_s.state = clock_loader_pkg::LINK_IDLE;
		end
	end

	always_ff @(posedge clk_in) begin
		s <= next_s;
	end

	// ==========================================================
	// link pins straight from flops
	assign link.serial_shift_clock  = s.sclk;
	assign link.serial_data         = s.sdata;
	assign link.serial_latch_enable = s.latch;
endmodule : serial_config_host
